// ---- rtl/trailer_pkg.sv ----
/*
 * Shared constants and carriers for the message trailer framer:
 * field offsets, selector encodings, reset values, ASCII codes.
 * Assumes one clock domain and byte-wide streams on both links.
 */
package trailer_pkg;

	// Field offsets of the protocol control register
	localparam logic [2:0] OFS_SER_CNT   = 3'h0;
	localparam logic [2:0] OFS_SER_STAT  = 3'h1;
	localparam logic [2:0] OFS_SPI_CNT   = 3'h2;
	localparam logic [2:0] OFS_SPI_STAT  = 3'h3;
	localparam logic [2:0] OFS_SER_INTEG = 3'h4;
	localparam logic [2:0] OFS_SPI_INTEG = 3'h5;
	localparam logic [2:0] OFS_ERR_MODE  = 3'h6;

	// Counter trailer selector
	localparam logic [1:0] CNT_NONE      = 2'h0;
	localparam logic [1:0] CNT_IN_COUNT  = 2'h1;
	localparam logic [1:0] CNT_IN_TIME   = 2'h2;
	localparam logic [1:0] CNT_OUT_COUNT = 2'h3;

	// Integrity selector
	localparam logic [1:0] CK_NONE  = 2'h0;
	localparam logic [1:0] CK_SUM8  = 2'h1;
	localparam logic [1:0] CK_CRC16 = 2'h2;

	// Error action selector
	localparam logic [1:0] ERR_IGNORE   = 2'h0;
	localparam logic [1:0] ERR_SEND     = 2'h1;
	localparam logic [1:0] ERR_SEND_OFF = 2'h2;

	// Largest legal value written to each field
	localparam logic [7:0] MAX_CNT_SEL = 8'h03;
	localparam logic [7:0] MAX_ENABLE  = 8'h01;
	localparam logic [7:0] MAX_INTEG   = 8'h02;
	localparam logic [7:0] MAX_ERR     = 8'h02;

	// Reset values of the fields
	localparam logic [1:0] RST_SER_CNT   = 2'h2;
	localparam logic       RST_SER_STAT  = 1'b0;
	localparam logic [1:0] RST_SPI_CNT   = 2'h0;
	localparam logic       RST_SPI_STAT  = 1'b0;
	localparam logic [1:0] RST_SER_INTEG = 2'h1;
	localparam logic [1:0] RST_SPI_INTEG = 2'h0;
	localparam logic [1:0] RST_ERR_MODE  = 2'h1;

	localparam logic [15:0] CRC_POLY = 16'h0007;
	localparam logic [15:0] ACC_INIT = 16'h0000;

	// ASCII codes
	localparam logic [7:0] CH_DOLLAR = 8'h24;
	localparam logic [7:0] CH_COMMA  = 8'h2c;
	localparam logic [7:0] CH_STAR   = 8'h2a;
	localparam logic [7:0] CH_S      = 8'h53;
	localparam logic [7:0] CH_T      = 8'h54;
	localparam logic [7:0] CH_CR     = 8'h0d;
	localparam logic [7:0] CH_LF     = 8'h0a;
	localparam logic [7:0] CH_0      = 8'h30;
	localparam logic [7:0] CH_A_OFS  = 8'h37;

	// Error sentence head after the dollar sign, comma included
	localparam logic [47:0] ERR_HEAD = 48'h564e4552522c;

	// Last index of each serial field and each binary field
	localparam logic [3:0] SER_STAT_LAST = 4'h5;
	localparam logic [3:0] SER_CNT_LAST  = 4'h9;
	localparam logic [3:0] ERR_HEAD_LAST = 4'h5;
	localparam logic [3:0] ERR_CODE_LAST = 4'h1;
	localparam logic [3:0] SUM8_DIG_LAST = 4'h1;
	localparam logic [3:0] CRC_DIG_LAST  = 4'h3;
	localparam logic [1:0] SPI_CNT_LAST  = 2'h3;
	localparam logic [1:0] SPI_STAT_LAST = 2'h1;
	localparam logic [1:0] SPI_CRC_LAST  = 2'h1;
	localparam logic [1:0] SPI_SUM_LAST  = 2'h0;

	typedef struct packed {
		logic       valid;
		logic       last;
		logic [7:0] data;
	} byte_beat_t;

	typedef struct packed {
		logic [31:0] in_count;
		logic [31:0] in_time;
		logic [31:0] out_count;
		logic [15:0] status;
	} sync_values_t;

endpackage : trailer_pkg

// ---- rtl/trailer_framer.sv ----
/*
 * Trailer framer: appends status, counter and integrity fields to
 * serial ASCII sentences and binary SPI packets, emits error sentences.
 * Assumes body streams and error events come from logic on core_clk_in.
 */
// Summary of operation
// R1: Serial counter trailer chosen by two-bit selector
// R2: Counter values taken live from sync status
// R3: Counter field is last before checksum star
// R4: Counter field starts with letter T
// R5: Status field appended when serial flag set
// R6: Status field goes before counter field
// R7: Status is S plus four hex digits
// R8: SPI counter appended using same selector codes
// R9: SPI status word appended when flag set
// R10: Serial integrity: none, sum8 or CRC16
// R11: Sum8 is XOR of sentence characters
// R12: CRC16 uses generator polynomial CRC_POLY
// R13: Serial CRC printed as four hex digits
// R14: SPI integrity appended after packet data
// R15: SPI CRC computed like serial CRC
// R16: Error sentence sent when action is one
// R17: Every error event increments readable tally
// R18: Action two also turns periodic output off
// R19: Checksum covers characters between dollar and star
// R20: Illegal selector writes keep previous value
`timescale 1ns/1ps
`default_nettype none

module trailer_framer #(
	parameter int TALLY_W = 16
) (
	input  wire logic                      core_clk_in,
	input  wire logic                      resetn_in,
	input  wire logic                      reg_wr_in,
	input  wire logic [2:0]                reg_addr_in,
	input  wire logic [7:0]                reg_wdata_in,
	output var  logic [7:0]                reg_rdata_out,
	input  wire trailer_pkg::sync_values_t sync_vals_in,
	input  wire trailer_pkg::byte_beat_t   ser_in,
	output var  logic                      ser_ready_out,
	output var  trailer_pkg::byte_beat_t   ser_tx_out,
	input  wire logic                      ser_tx_ready_in,
	input  wire trailer_pkg::byte_beat_t   spi_in,
	output var  logic                      spi_ready_out,
	output var  trailer_pkg::byte_beat_t   spi_tx_out,
	input  wire logic                      spi_tx_ready_in,
	input  wire logic                      err_event_in,
	input  wire logic [7:0]                err_code_in,
	output var  logic [TALLY_W-1:0]        error_event_tally_out,
	output var  logic                      async_output_type_off_out
);
	import trailer_pkg::*;

	typedef enum logic [3:0] {S_IDLE, S_BODY, S_STAT, S_CNT, S_STAR, S_CS,
		S_CR, S_LF, S_EHDR, S_ECODE} ser_state_t;
	typedef enum logic [1:0] {P_BODY, P_CNT, P_STAT, P_CS} spi_state_t;

	function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		logic        fb;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			fb = r[15] ^ b[i];
			r = {r[14:0], 1'b0};
			if (fb) r = r ^ CRC_POLY;
		end
		return r;
	endfunction : crc_upd

	function automatic logic [7:0] hex_ch(input logic [3:0] n);
		return (n < 4'ha) ? CH_0 + {4'h0, n} : CH_A_OFS + {4'h0, n};
	endfunction : hex_ch

	// Comma, prefix letter, then hex digits of w from the top
	function automatic logic [7:0] field_ch(input logic [3:0] i, input logic [7:0] pfx,
			input logic [31:0] w);
		logic [3:0]  k;
		logic [31:0] t;
		k = i - 4'h2;
		t = w << {k, 2'b00};
		if (i == 4'h0) return CH_COMMA;
		if (i == 4'h1) return pfx;
		return hex_ch(t[31:28]);
	endfunction : field_ch

	function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] i);
		logic [31:0] t;
		t = w >> {i, 3'b000};
		return t[7:0];
	endfunction : byte_of

	function automatic logic [31:0] pick_cnt(input logic [1:0] s, input sync_values_t v);
		return (s == CNT_IN_COUNT) ? v.in_count :
			(s == CNT_IN_TIME) ? v.in_time : v.out_count;
	endfunction : pick_cnt

	// Configuration fields
	logic [1:0]         ser_cnt_r, spi_cnt_r, ser_integ_r, spi_integ_r, err_mode_r;
	logic               ser_stat_r, spi_stat_r;
	logic [7:0]         rdata_nxt;
	logic [TALLY_W-1:0] tally_r;
	logic               off_r, err_pend_r, err_start;
	logic [7:0]         err_code_r;

	wire wr_ser_cnt   = reg_wr_in && reg_addr_in == OFS_SER_CNT && reg_wdata_in <= MAX_CNT_SEL;
	wire wr_ser_stat  = reg_wr_in && reg_addr_in == OFS_SER_STAT && reg_wdata_in <= MAX_ENABLE;
	wire wr_spi_cnt   = reg_wr_in && reg_addr_in == OFS_SPI_CNT && reg_wdata_in <= MAX_CNT_SEL;
	wire wr_spi_stat  = reg_wr_in && reg_addr_in == OFS_SPI_STAT && reg_wdata_in <= MAX_ENABLE;
	wire wr_ser_integ = reg_wr_in && reg_addr_in == OFS_SER_INTEG && reg_wdata_in <= MAX_INTEG;
	wire wr_spi_integ = reg_wr_in && reg_addr_in == OFS_SPI_INTEG && reg_wdata_in <= MAX_INTEG;
	wire wr_err_mode  = reg_wr_in && reg_addr_in == OFS_ERR_MODE && reg_wdata_in <= MAX_ERR;

	always_comb begin
		unique case (reg_addr_in)
			OFS_SER_CNT:   rdata_nxt = {6'h00, ser_cnt_r};
			OFS_SER_STAT:  rdata_nxt = {7'h00, ser_stat_r};
			OFS_SPI_CNT:   rdata_nxt = {6'h00, spi_cnt_r};
			OFS_SPI_STAT:  rdata_nxt = {7'h00, spi_stat_r};
			OFS_SER_INTEG: rdata_nxt = {6'h00, ser_integ_r};
			OFS_SPI_INTEG: rdata_nxt = {6'h00, spi_integ_r};
			OFS_ERR_MODE:  rdata_nxt = {6'h00, err_mode_r};
			default:       rdata_nxt = 8'h00;
		endcase
	end

	// Out-of-range values leave the field untouched [R20]
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ser_cnt_r     <= RST_SER_CNT;
			ser_stat_r    <= RST_SER_STAT;
			spi_cnt_r     <= RST_SPI_CNT;
			spi_stat_r    <= RST_SPI_STAT;
			ser_integ_r   <= RST_SER_INTEG;
			spi_integ_r   <= RST_SPI_INTEG;
			err_mode_r    <= RST_ERR_MODE;
			reg_rdata_out <= 8'h00;
		end else begin
			if (wr_ser_cnt) ser_cnt_r <= reg_wdata_in[1:0];
			if (wr_ser_stat) ser_stat_r <= reg_wdata_in[0];
			if (wr_spi_cnt) spi_cnt_r <= reg_wdata_in[1:0];
			if (wr_spi_stat) spi_stat_r <= reg_wdata_in[0];
			if (wr_ser_integ) ser_integ_r <= reg_wdata_in[1:0];
			if (wr_spi_integ) spi_integ_r <= reg_wdata_in[1:0];
			if (wr_err_mode) err_mode_r <= reg_wdata_in[1:0];
			reg_rdata_out <= rdata_nxt;
		end
	end

	// Error handling; a new event wins over the clear at sentence start
	wire err_report = err_event_in && err_mode_r != ERR_IGNORE;

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			tally_r    <= '0;
			off_r      <= 1'b0;
			err_pend_r <= 1'b0;
			err_code_r <= 8'h00;
		end else begin
			tally_r    <= tally_r + TALLY_W'(err_event_in);           // [R17]
			off_r      <= err_event_in && err_mode_r == ERR_SEND_OFF;  // [R18]
			err_pend_r <= err_report || (err_pend_r && !err_start);   // [R16]
			if (err_report) err_code_r <= err_code_in;
		end
	end

	assign error_event_tally_out     = tally_r;
	assign async_output_type_off_out = off_r;

	// Serial sentence engine
	ser_state_t  s_state_r, s_state_nxt;
	logic [3:0]  s_idx_r, s_idx_nxt;
	logic [15:0] s_acc_r, s_acc_nxt;
	byte_beat_t  s_tx_r, s_tx_nxt;
	logic        s_rdy_r, s_emit, s_sum, s_last;
	logic [7:0]  s_ch;

	wire         s_slot       = !s_tx_r.valid || ser_tx_ready_in;
	wire         s_take       = ser_in.valid && s_rdy_r;
	wire [31:0]  s_cnt_word   = pick_cnt(ser_cnt_r, sync_vals_in);             // [R2]
	wire [31:0]  s_stat_word  = {sync_vals_in.status, 16'h0000};
	wire         s_sum8       = ser_integ_r == CK_SUM8;
	wire [15:0]  s_cs_word    = s_sum8 ? {s_acc_r[7:0], 8'h00} : s_acc_r;
	wire [15:0]  s_cs_shift   = s_cs_word << {s_idx_r[1:0], 2'b00};
	wire [3:0]   s_cs_last    = s_sum8 ? SUM8_DIG_LAST : CRC_DIG_LAST;         // [R13]
	wire [47:0]  s_head_shift = ERR_HEAD << {s_idx_r, 3'b000};
	ser_state_t  s_after_stat, s_after_body;
	assign s_after_stat = (ser_cnt_r != CNT_NONE) ? S_CNT : S_STAR;          // [R1] [R3]
	assign s_after_body = ser_stat_r ? S_STAT : s_after_stat;                // [R5] [R6]
	wire         s_rdy_nxt    = s_state_nxt == S_BODY && !s_tx_nxt.valid;

	always_comb begin
		s_state_nxt = s_state_r;
		s_idx_nxt   = s_idx_r;
		s_acc_nxt   = s_acc_r;
		s_tx_nxt    = s_tx_r;
		if (ser_tx_ready_in) s_tx_nxt.valid = 1'b0;
		s_emit      = 1'b0;
		s_sum       = 1'b0;
		s_last      = 1'b0;
		s_ch        = 8'h00;
		err_start   = 1'b0;
		unique case (s_state_r)
			S_IDLE: begin
				if (err_pend_r && s_slot) begin
					s_emit      = 1'b1;
					s_ch        = CH_DOLLAR;
					s_acc_nxt   = ACC_INIT;
					s_idx_nxt   = 4'h0;
					s_state_nxt = S_EHDR;
					err_start   = 1'b1;
				end else if (ser_in.valid) begin
					s_acc_nxt   = ACC_INIT;
					s_state_nxt = S_BODY;
				end
			end
			S_BODY: if (s_take) begin
				s_emit = 1'b1;
				s_ch   = ser_in.data;
				s_sum  = ser_in.data != CH_DOLLAR;                           // [R19]
				if (ser_in.last) begin
					s_idx_nxt   = 4'h0;
					s_state_nxt = s_after_body;
				end
			end
			S_STAT: if (s_slot) begin
				s_emit = 1'b1;
				s_sum  = 1'b1;
				s_ch   = field_ch(s_idx_r, CH_S, s_stat_word);                // [R7]
				s_idx_nxt = s_idx_r + 4'h1;
				if (s_idx_r == SER_STAT_LAST) begin
					s_idx_nxt   = 4'h0;
					s_state_nxt = s_after_stat;
				end
			end
			S_CNT: if (s_slot) begin
				s_emit = 1'b1;
				s_sum  = 1'b1;
				s_ch   = field_ch(s_idx_r, CH_T, s_cnt_word);                 // [R4]
				s_idx_nxt = s_idx_r + 4'h1;
				if (s_idx_r == SER_CNT_LAST) begin
					s_idx_nxt   = 4'h0;
					s_state_nxt = S_STAR;
				end
			end
			S_EHDR: if (s_slot) begin
				s_emit = 1'b1;
				s_sum  = 1'b1;
				s_ch   = s_head_shift[47:40];
				s_idx_nxt = s_idx_r + 4'h1;
				if (s_idx_r == ERR_HEAD_LAST) begin
					s_idx_nxt   = 4'h0;
					s_state_nxt = S_ECODE;
				end
			end
			S_ECODE: if (s_slot) begin
				s_emit = 1'b1;
				s_sum  = 1'b1;
				s_ch   = hex_ch(s_idx_r[0] ? err_code_r[3:0] : err_code_r[7:4]);
				s_idx_nxt = s_idx_r + 4'h1;
				if (s_idx_r == ERR_CODE_LAST) begin
					s_idx_nxt   = 4'h0;
					s_state_nxt = S_STAR;
				end
			end
			S_STAR: if (s_slot) begin
				if (ser_integ_r == CK_NONE) s_state_nxt = S_CR;              // [R10]
				else begin
					s_emit      = 1'b1;
					s_ch        = CH_STAR;
					s_idx_nxt   = 4'h0;
					s_state_nxt = S_CS;
				end
			end
			S_CS: if (s_slot) begin
				s_emit = 1'b1;
				s_ch   = hex_ch(s_cs_shift[15:12]);
				s_idx_nxt = s_idx_r + 4'h1;
				if (s_idx_r == s_cs_last) s_state_nxt = S_CR;
			end
			S_CR: if (s_slot) begin
				s_emit      = 1'b1;
				s_ch        = CH_CR;
				s_state_nxt = S_LF;
			end
			S_LF: if (s_slot) begin
				s_emit      = 1'b1;
				s_last      = 1'b1;
				s_ch        = CH_LF;
				s_state_nxt = S_IDLE;
			end
		endcase
		if (s_emit) begin
			s_tx_nxt = '{valid: 1'b1, last: s_last, data: s_ch};
			if (s_sum) s_acc_nxt = (ser_integ_r == CK_CRC16) ? crc_upd(s_acc_r, s_ch) // [R12]
				: {8'h00, s_acc_r[7:0] ^ s_ch};                              // [R11]
		end
	end

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s_state_r <= S_IDLE;
			s_idx_r   <= 4'h0;
			s_acc_r   <= ACC_INIT;
			s_tx_r    <= '0;
			s_rdy_r   <= 1'b0;
		end else begin
			s_state_r <= s_state_nxt;
			s_idx_r   <= s_idx_nxt;
			s_acc_r   <= s_acc_nxt;
			s_tx_r    <= s_tx_nxt;
			s_rdy_r   <= s_rdy_nxt;
		end
	end

	assign ser_tx_out    = s_tx_r;
	assign ser_ready_out = s_rdy_r;

	// Binary SPI packet engine
	spi_state_t  p_state_r, p_state_nxt;
	logic [1:0]  p_idx_r, p_idx_nxt;
	logic [15:0] p_acc_r, p_acc_nxt;
	byte_beat_t  p_tx_r, p_tx_nxt;
	logic        p_rdy_r, p_emit, p_sum, p_last;
	logic [7:0]  p_ch;

	wire         p_slot     = !p_tx_r.valid || spi_tx_ready_in;
	wire         p_take     = spi_in.valid && p_rdy_r;
	wire [31:0]  p_cnt_word = pick_cnt(spi_cnt_r, sync_vals_in);               // [R2]
	wire         p_sum8     = spi_integ_r == CK_SUM8;
	wire [15:0]  p_cs_word  = p_sum8 ? {p_acc_r[7:0], 8'h00} : p_acc_r;
	wire [15:0]  p_cs_shift = p_cs_word << {p_idx_r[0], 3'b000};
	wire [1:0]   p_cs_last  = p_sum8 ? SPI_SUM_LAST : SPI_CRC_LAST;
	spi_state_t  p_after_stat, p_after_cnt, p_after_body;
	assign p_after_stat = (spi_integ_r != CK_NONE) ? P_CS : P_BODY;           // [R14]
	assign p_after_cnt  = spi_stat_r ? P_STAT : p_after_stat;                 // [R9]
	assign p_after_body = (spi_cnt_r != CNT_NONE) ? P_CNT : p_after_cnt;      // [R8]
	wire         p_rdy_nxt  = p_state_nxt == P_BODY && !p_tx_nxt.valid;

	always_comb begin
		p_state_nxt = p_state_r;
		p_idx_nxt   = p_idx_r;
		p_acc_nxt   = p_acc_r;
		p_tx_nxt    = p_tx_r;
		if (spi_tx_ready_in) p_tx_nxt.valid = 1'b0;
		p_emit      = 1'b0;
		p_sum       = 1'b0;
		p_last      = 1'b0;
		p_ch        = 8'h00;
		unique case (p_state_r)
			P_BODY: if (p_take) begin
				p_emit = 1'b1;
				p_sum  = 1'b1;
				p_ch   = spi_in.data;
				if (spi_in.last) begin
					p_idx_nxt   = 2'h0;
					p_state_nxt = p_after_body;
					p_last      = p_after_body == P_BODY;
				end
			end
			P_CNT: if (p_slot) begin
				p_emit    = 1'b1;
				p_sum     = 1'b1;
				p_ch      = byte_of(p_cnt_word, p_idx_r);
				p_idx_nxt = p_idx_r + 2'h1;
				if (p_idx_r == SPI_CNT_LAST) begin
					p_idx_nxt   = 2'h0;
					p_state_nxt = p_after_cnt;
					p_last      = p_after_cnt == P_BODY;
				end
			end
			P_STAT: if (p_slot) begin
				p_emit    = 1'b1;
				p_sum     = 1'b1;
				p_ch      = byte_of({16'h0000, sync_vals_in.status}, p_idx_r);
				p_idx_nxt = p_idx_r + 2'h1;
				if (p_idx_r == SPI_STAT_LAST) begin
					p_idx_nxt   = 2'h0;
					p_state_nxt = p_after_stat;
					p_last      = p_after_stat == P_BODY;
				end
			end
			P_CS: if (p_slot) begin
				p_emit    = 1'b1;
				p_ch      = p_cs_shift[15:8];
				p_idx_nxt = p_idx_r + 2'h1;
				if (p_idx_r == p_cs_last) begin
					p_idx_nxt   = 2'h0;
					p_state_nxt = P_BODY;
					p_last      = 1'b1;
				end
			end
		endcase
		if (p_emit) begin
			p_tx_nxt = '{valid: 1'b1, last: p_last, data: p_ch};
			if (p_sum) p_acc_nxt = (spi_integ_r == CK_CRC16) ? crc_upd(p_acc_r, p_ch) // [R15]
				: {8'h00, p_acc_r[7:0] ^ p_ch};
			if (p_last) p_acc_nxt = ACC_INIT;
		end
	end

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			p_state_r <= P_BODY;
			p_idx_r   <= 2'h0;
			p_acc_r   <= ACC_INIT;
			p_tx_r    <= '0;
			p_rdy_r   <= 1'b0;
		end else begin
			p_state_r <= p_state_nxt;
			p_idx_r   <= p_idx_nxt;
			p_acc_r   <= p_acc_nxt;
			p_tx_r    <= p_tx_nxt;
			p_rdy_r   <= p_rdy_nxt;
		end
	end

	assign spi_tx_out    = p_tx_r;
	assign spi_ready_out = p_rdy_r;

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);

	chk_tally_step: assert property (err_event_in |=> tally_r == $past(tally_r) + 1'b1) // [R17]
		else $error("error tally did not step");
	chk_off_pulse: assert property ((err_event_in && err_mode_r == ERR_SEND_OFF) |=> off_r) // [R18]
		else $error("output-off pulse missing");
	chk_err_sent: assert property (err_report |-> ##[1:300] (s_state_r == S_EHDR)) // [R16]
		else $error("error sentence not started");
	chk_no_err_ignore: assert property ((err_mode_r == ERR_IGNORE && !err_pend_r) |=> !err_pend_r) // [R16]
		else $error("error pending while ignored");
	chk_reject_write: assert property ((reg_wr_in && reg_addr_in == OFS_SER_INTEG && reg_wdata_in > MAX_INTEG) |=> $stable(ser_integ_r)) // [R20]
		else $error("illegal selector accepted");
	chk_status_first: assert property ((s_take && s_state_r == S_BODY && ser_in.last && ser_stat_r) |=> s_state_r == S_STAT) // [R6]
		else $error("status field not first");
	chk_t_prefix: assert property ((s_state_r == S_CNT && s_idx_r == 4'h1 && s_slot) |=> s_tx_r.data == CH_T) // [R4]
		else $error("counter prefix wrong");
	chk_s_prefix: assert property ((s_state_r == S_STAT && s_idx_r == 4'h1 && s_slot) |=> s_tx_r.data == CH_S) // [R7]
		else $error("status prefix wrong");
	chk_star_after: assert property ((s_state_r == S_CNT && s_idx_r == SER_CNT_LAST && s_slot) |=> s_state_r == S_STAR) // [R3]
		else $error("counter not last field");
	chk_spi_counter: assert property ((p_take && spi_in.last && spi_cnt_r != CNT_NONE) |=> p_state_r == P_CNT) // [R8]
		else $error("spi counter skipped");

	cov_err_sentence: cover property (s_state_r == S_ECODE ##1 s_state_r == S_STAR);
	cov_both_fields: cover property (s_state_r == S_STAT ##[1:40] s_state_r == S_CNT);
	cov_spi_crc: cover property (p_state_r == P_CS && spi_integ_r == CK_CRC16 && p_slot);

endmodule : trailer_framer

`default_nettype wire

// ---- sim/host_sink.sv ----
/*
 * Host-side sink for both links: accepts serial and SPI bytes,
 * stalling at random. Assumes the framer's clock and reset.
 */
`timescale 1ns/1ps
`default_nettype none

module host_sink (
	input  wire logic core_clk_in,
	input  wire logic resetn_in,
	output var  logic ser_ready_out,
	output var  logic spi_ready_out
);
	integer seed = 32'h3994;

	// Ready drops about one cycle in four
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ser_ready_out <= 1'b0;
			spi_ready_out <= 1'b0;
		end else begin
			ser_ready_out <= ($random(seed) & 32'h3) != 32'h0;
			spi_ready_out <= ($random(seed) & 32'h3) != 32'h0;
		end
	end
endmodule : host_sink

`default_nettype wire

// ---- sim/comm_protocol_trailer_control_tb.sv ----
/*
 * Bench for trailer_framer: fields, sentences, packets, error events;
 * a monitor pops expected bytes. Assumes host_sink drives tx readies.
 */
`timescale 1ns/1ps
`default_nettype none

module comm_protocol_trailer_control_tb;
	import trailer_pkg::*;
	logic         core_clk_in  = 1'b0;
	logic         resetn_in    = 1'b0;
	logic         reg_wr_in    = 1'b0;
	logic [2:0]   reg_addr_in  = 3'h0;
	logic [7:0]   reg_wdata_in = 8'h00;
	logic [7:0]   reg_rdata_out;
	sync_values_t sync_vals_in = '0;
	byte_beat_t   ser_in       = '0;
	byte_beat_t   spi_in       = '0;
	byte_beat_t   ser_tx_out;
	byte_beat_t   spi_tx_out;
	logic         ser_ready_out;
	logic         spi_ready_out;
	logic         ser_tx_ready_in;
	logic         spi_tx_ready_in;
	logic         err_event_in = 1'b0;
	logic [7:0]   err_code_in  = 8'h00;
	logic [15:0]  error_event_tally_out;
	logic         async_output_type_off_out;
	integer       seed         = 32'h3994;
	int           error_cnt    = 0;
	int           cmp_count    = 0;
	int           off_seen     = 0;
	int           exp_off      = 0;
	logic [8:0]   ser_q[$];
	logic [8:0]   spi_q[$];
	logic [7:0]   fld [0:6];
	logic [7:0]   sum;
	logic [15:0]  crc;

	always #5 core_clk_in = ~core_clk_in;

	trailer_framer dut (
		.core_clk_in(core_clk_in), .resetn_in(resetn_in), .reg_wr_in(reg_wr_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.reg_rdata_out(reg_rdata_out), .sync_vals_in(sync_vals_in),
		.ser_in(ser_in), .ser_ready_out(ser_ready_out), .ser_tx_out(ser_tx_out),
		.ser_tx_ready_in(ser_tx_ready_in), .spi_in(spi_in),
		.spi_ready_out(spi_ready_out), .spi_tx_out(spi_tx_out),
		.spi_tx_ready_in(spi_tx_ready_in), .err_event_in(err_event_in),
		.err_code_in(err_code_in), .error_event_tally_out(error_event_tally_out),
		.async_output_type_off_out(async_output_type_off_out)
	);

	host_sink sink (
		.core_clk_in(core_clk_in), .resetn_in(resetn_in),
		.ser_ready_out(ser_tx_ready_in), .spi_ready_out(spi_tx_ready_in)
	);

	task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp_val

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run

	// Transferred bytes checked in order
	always @(posedge core_clk_in) begin
		if (ser_tx_out.valid && ser_tx_ready_in)
			cmp_val("ser byte", 32'(ser_q.size() != 0 ? ser_q.pop_front() : 9'bx), 32'({ser_tx_out.last, ser_tx_out.data}));
		if (spi_tx_out.valid && spi_tx_ready_in)
			cmp_val("spi byte", 32'(spi_q.size() != 0 ? spi_q.pop_front() : 9'bx), 32'({spi_tx_out.last, spi_tx_out.data}));
		if (resetn_in && async_output_type_off_out)
			off_seen++;
	end

	function automatic logic [7:0] hexc(input logic [3:0] d);
		return (d < 4'ha) ? CH_0 + 8'(d) : CH_A_OFS + 8'(d);
	endfunction : hexc

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		c = c ^ {b, 8'h00};
		for (int i = 0; i < 8; i++)
			c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		return c;
	endfunction : crc_step

	function automatic logic [31:0] cnt_val(input logic [1:0] s);
		if (s == CNT_IN_COUNT)
			return sync_vals_in.in_count;
		return (s == CNT_IN_TIME) ? sync_vals_in.in_time : sync_vals_in.out_count;
	endfunction : cnt_val

	task automatic put(input bit spi, input logic [7:0] b, input bit last, input bit cov);
		if (cov) begin
			sum ^= b;
			crc = crc_step(crc, b);
		end
		if (spi)
			spi_q.push_back({last, b});
		else
			ser_q.push_back({last, b});
	endtask : put

	task automatic phex(input logic [31:0] v, input int nd, input bit cov);
		for (int k = 4 * nd - 4; k >= 0; k -= 4)
			put(1'b0, hexc(v[k+:4]), 1'b0, cov);
	endtask : phex

	task automatic ser_close();
		logic [7:0]  s;
		logic [15:0] c;
		s = sum;
		c = crc;
		if (fld[4][1:0] != CK_NONE)
			put(1'b0, CH_STAR, 1'b0, 1'b0);
		if (fld[4][1:0] == CK_SUM8)
			phex(32'(s), 2, 1'b0);
		if (fld[4][1:0] == CK_CRC16)
			phex(32'(c), 4, 1'b0);
		put(1'b0, CH_CR, 1'b0, 1'b0);
		put(1'b0, CH_LF, 1'b1, 1'b0);
	endtask : ser_close

	task automatic send(input bit spi, input logic [7:0] b, input bit last);
		@(posedge core_clk_in);
		if (spi)
			spi_in <= {1'b1, last, b};
		else
			ser_in <= {1'b1, last, b};
		do @(posedge core_clk_in); while (!(spi ? spi_ready_out : ser_ready_out));
		ser_in <= '0;
		spi_in <= '0;
	endtask : send

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge core_clk_in);
		reg_wr_in <= 1'b0;
		if (d <= ((a == 0 || a == 2) ? MAX_CNT_SEL : (a == 1 || a == 3) ? MAX_ENABLE : MAX_INTEG))
			fld[a] = d;
	endtask : wr

	task automatic rd_chk(input logic [2:0] a);
		@(posedge core_clk_in);
		reg_addr_in <= a;
		repeat (2) @(posedge core_clk_in);
		cmp_val("field", (a == 3'h7) ? 32'h0 : 32'(fld[a]), 32'(reg_rdata_out));
	endtask : rd_chk

	task automatic ser_frame(input int n);
		logic [7:0] bd [0:15];
		sum = 8'h00;
		crc = ACC_INIT;
		for (int i = 0; i < n; i++) begin
			bd[i] = (i == 0) ? CH_DOLLAR : 8'h41 + 8'($random(seed) & 15);
			put(1'b0, bd[i], 1'b0, i != 0);
		end
		if (fld[1][0]) begin
			put(1'b0, CH_COMMA, 1'b0, 1'b1);
			put(1'b0, CH_S, 1'b0, 1'b1);
			phex(32'(sync_vals_in.status), 4, 1'b1);
		end
		if (fld[0][1:0] != CNT_NONE) begin
			put(1'b0, CH_COMMA, 1'b0, 1'b1);
			put(1'b0, CH_T, 1'b0, 1'b1);
			phex(cnt_val(fld[0][1:0]), 8, 1'b1);
		end
		ser_close();
		for (int i = 0; i < n; i++)
			send(1'b0, bd[i], i == n - 1);
	endtask : ser_frame

	task automatic spi_frame(input int n);
		logic [7:0]  bd [0:15];
		logic [31:0] v;
		sum = 8'h00;
		crc = ACC_INIT;
		v = cnt_val(fld[2][1:0]);
		for (int i = 0; i < n; i++) begin
			bd[i] = 8'($random(seed));
			put(1'b1, bd[i], 1'b0, 1'b1);
		end
		if (fld[2][1:0] != CNT_NONE)
			for (int k = 0; k < 32; k += 8) put(1'b1, v[k+:8], 1'b0, 1'b1);
		if (fld[3][0])
			for (int k = 0; k < 16; k += 8) put(1'b1, sync_vals_in.status[k+:8], 1'b0, 1'b1);
		v = {16'h0, crc};
		if (fld[5][1:0] == CK_SUM8)
			put(1'b1, sum, 1'b0, 1'b0);
		if (fld[5][1:0] == CK_CRC16) begin
			put(1'b1, v[15:8], 1'b0, 1'b0);
			put(1'b1, v[7:0], 1'b0, 1'b0);
		end
		spi_q.push_back(spi_q.pop_back() | 9'h100);
		for (int i = 0; i < n; i++)
			send(1'b1, bd[i], i == n - 1);
	endtask : spi_frame

	task automatic err_evt(input logic [7:0] code);
		logic [15:0] t;
		t = error_event_tally_out;
		if (fld[6][1:0] != ERR_IGNORE) begin
			sum = 8'h00;
			crc = ACC_INIT;
			put(1'b0, CH_DOLLAR, 1'b0, 1'b0);
			for (int k = 40; k >= 0; k -= 8) put(1'b0, ERR_HEAD[k+:8], 1'b0, 1'b1);
			phex(32'(code), 2, 1'b1);
			ser_close();
		end
		exp_off += int'(fld[6][1:0] == ERR_SEND_OFF);
		@(posedge core_clk_in);
		err_event_in <= 1'b1;
		err_code_in <= code;
		@(posedge core_clk_in);
		err_event_in <= 1'b0;
		repeat (2) @(posedge core_clk_in);
		cmp_val("tally", 32'(t + 16'h1), 32'(error_event_tally_out));
	endtask : err_evt

	task automatic drain();
		for (int i = 0; i < 4000 && (ser_q.size() + spi_q.size()) != 0; i++)
			@(posedge core_clk_in);
		cmp_val("queued", 32'h0, 32'(ser_q.size() + spi_q.size()));
	endtask : drain

	initial begin
		#500000;
		error_cnt++;
		$display("watchdog expired");
		complete_run();
	end

	initial begin
		fld = '{8'(RST_SER_CNT), 8'(RST_SER_STAT), 8'(RST_SPI_CNT), 8'(RST_SPI_STAT),
			8'(RST_SER_INTEG), 8'(RST_SPI_INTEG), 8'(RST_ERR_MODE)};
		repeat (2) @(posedge core_clk_in);
		resetn_in <= 1'b1;
		for (int a = 0; a < 8; a++) rd_chk(3'(a));
		$display("test reset values done");
		wr(OFS_SER_CNT, 8'h04);
		wr(OFS_SER_INTEG, 8'h03);
		wr(OFS_ERR_MODE, 8'hff);
		wr(OFS_SPI_STAT, 8'h02);
		for (int a = 0; a < 7; a++) rd_chk(3'(a));
		$display("test illegal writes done");
		for (int c = 0; c < 12; c++) begin
			wr(OFS_SER_CNT, 8'(c % 4));
			wr(OFS_SPI_CNT, 8'(c % 4));
			wr(OFS_SER_STAT, 8'(c % 2));
			wr(OFS_SPI_STAT, 8'((c / 2) % 2));
			wr(OFS_SER_INTEG, 8'(c / 4));
			wr(OFS_SPI_INTEG, 8'(c / 4));
			@(posedge core_clk_in);
			sync_vals_in <= {$random(seed), $random(seed), $random(seed), 16'($random(seed))};
			@(posedge core_clk_in);
			ser_frame(4 + c % 5);
			spi_frame(1 + c % 4);
			drain();
		end
		$display("test trailers done");
		for (int m = 0; m < 3; m++) begin
			wr(OFS_ERR_MODE, 8'(m));
			err_evt(8'h03 + 8'(m));
			drain();
		end
		cmp_val("off pulses", 32'(exp_off), 32'(off_seen));
		$display("test error actions done");
		complete_run();
	end
endmodule : comm_protocol_trailer_control_tb

`default_nettype wire
